// File: pec_defs.vh
// register map, field positions and reset values of the pin edge change block
`ifndef PEC_DEFS_VH
`define PEC_DEFS_VH

// ==========================================================
// register byte offsets on the wishbone bus
`define PEC_OFS_A_RISE   8'h00
`define PEC_OFS_A_FALL   8'h04
`define PEC_OFS_A_FLAGS  8'h08
`define PEC_OFS_B_RISE   8'h0c
`define PEC_OFS_B_FALL   8'h10
`define PEC_OFS_B_FLAGS  8'h14
`define PEC_OFS_C_RISE   8'h18
`define PEC_OFS_C_FALL   8'h1c
`define PEC_OFS_C_FLAGS  8'h20
`define PEC_OFS_INTCTL   8'h24
`define PEC_OFS_STATUS   8'h28
`define PEC_OFS_MASK     8'h2c

// ==========================================================
// implemented bits of each port register
`define PEC_MASK_A       8'h3f
`define PEC_MASK_B_BIG   8'hf0
`define PEC_MASK_B_SMALL 8'h00
`define PEC_MASK_C_BIG   8'hff
`define PEC_MASK_C_SMALL 8'h3f

// ==========================================================
// interrupt control fields
`define PEC_BIT_CFLAG    0
`define PEC_BIT_CEN      3

// ==========================================================
// event status bits, one per port
`define PEC_ST_A         0
`define PEC_ST_B         1
`define PEC_ST_C         2
`define PEC_ST_W         3

// ==========================================================
// reset values and widths
`define PEC_RST_BYTE     8'h00
`define PEC_RST_WORD     32'h00000000
`define PEC_RST_ST       3'h0
`define PEC_ADDR_W       8
`define PEC_SYNC_SETTLE  2'h3

`endif

// File: pec_edge_detect.v
// pin synchroniser and edge detector for one eight-bit port
`include "pec_defs.vh"

module pec_edge_detect (
    input  wire       clk,      // system clock
    input  wire       arst_n,   // asynchronous reset, active low
    input  wire [7:0] pin,      // raw port pins
    output reg  [7:0] rise,     // one-cycle pulse per rising pin
    output reg  [7:0] fall      // one-cycle pulse per falling pin
);

    reg [7:0] syncA;    // first stage, read only by syncB
    reg [7:0] syncB;    // second stage, safe to use
    reg [7:0] prevB;    // previous safe sample
    reg [1:0] settle;   // counts stages filled after reset

    // ==========================================================
    // two flops into the clock domain, then one history flop
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA  <= `PEC_RST_BYTE;
            syncB  <= `PEC_RST_BYTE;
            prevB  <= `PEC_RST_BYTE;
            settle <= 2'h0;
            rise   <= `PEC_RST_BYTE;
            fall   <= `PEC_RST_BYTE;
        end else begin
            syncA <= pin;
            syncB <= syncA;
            prevB <= syncB;
            // a high pin at release must not look like a rising edge
            if (settle != `PEC_SYNC_SETTLE) begin
                settle <= settle + 2'h1;
                rise   <= `PEC_RST_BYTE;
                fall   <= `PEC_RST_BYTE;
            end else begin
                rise <= syncB & ~prevB;
                fall <= ~syncB & prevB;
            end
        end
    end

endmodule

// File: pec_top.v
// pin edge change interrupt block with a wishbone register slave
// ==========================================================
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`include "pec_defs.vh"

module pec_top #(
    parameter LARGE_VARIANT = 1          // 1 keeps port B and port C bits 7:6
) (
    input  wire        clk,              // system clock, 20 MHz
    input  wire        arst_n,           // asynchronous reset, active low
    input  wire [7:0]  port_a_pin,       // port A pins, bits 5:0 used
    input  wire [7:0]  port_b_pin,       // port B pins, bits 7:4 used on the large variant
    input  wire [7:0]  port_c_pin,       // port C pins
    input  wire        wb_cyc_i,         // wishbone cycle
    input  wire        wb_stb_i,         // wishbone strobe
    input  wire        wb_we_i,          // wishbone write enable
    input  wire [7:0]  wb_adr_i,         // wishbone byte address
    input  wire [3:0]  wb_sel_i,         // wishbone byte lanes
    input  wire [31:0] wb_dat_i,         // wishbone write data
    output reg  [31:0] wb_dat_o,         // wishbone read data
    output reg         wb_ack_o,         // wishbone acknowledge
    output reg         irq               // level interrupt, active high
);

    // ==========================================================
    // implemented bits per port, fixed by the variant
    // unimplemented bits are masked on write and on set, so they
    // can never read back as one, whatever software writes
    localparam [7:0] MASK_A = `PEC_MASK_A;
    localparam [7:0] MASK_B = LARGE_VARIANT ? `PEC_MASK_B_BIG
                                            : `PEC_MASK_B_SMALL;
    localparam [7:0] MASK_C = LARGE_VARIANT ? `PEC_MASK_C_BIG
                                            : `PEC_MASK_C_SMALL;

    // ==========================================================
    // register storage
    // port A: pins 5:0 only
    reg [7:0] port_a_rise_enable;    // port A rising enables
    reg [7:0] port_a_fall_enable;    // port A falling enables
    reg [7:0] port_a_change_flags;   // port A pin flags
    // port B: pins 7:4, large variant only
    reg [7:0] port_b_rise_enable;    // port B rising enables
    reg [7:0] port_b_fall_enable;    // port B falling enables
    reg [7:0] port_b_change_flags;   // port B pin flags
    // port C: all pins, 7:6 on the large variant only
    reg [7:0] port_c_rise_enable;    // port C rising enables
    reg [7:0] port_c_fall_enable;    // port C falling enables
    reg [7:0] port_c_change_flags;   // port C pin flags
    // interrupt control, event status and mask
    reg       common_change_interrupt_enable; // gates the common flag
    reg [`PEC_ST_W-1:0] eventStatus; // sticky per-port event bits
    reg [`PEC_ST_W-1:0] eventMask;   // enables for eventStatus

    // ==========================================================
    // edge pulses from the synchronisers
    // each pulse is one cycle wide and stays low while settling
    wire [7:0] riseA;    // port A rising pulses
    wire [7:0] fallA;    // port A falling pulses
    wire [7:0] riseB;    // port B rising pulses
    wire [7:0] fallB;    // port B falling pulses
    wire [7:0] riseC;    // port C rising pulses
    wire [7:0] fallC;    // port C falling pulses

    // ==========================================================
    // one synchroniser per port
    // the pins count as synchronous, but a second flop costs little
    // and keeps a slow edge from splitting across two cycles
    // port A keeps pins 7:6 masked on both variants
    pec_edge_detect edgeA (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (port_a_pin),
        .rise   (riseA),
        .fall   (fallA)
    );

    // port B still runs on the small variant; its events are masked
    pec_edge_detect edgeB (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (port_b_pin),
        .rise   (riseB),
        .fall   (fallB)
    );

    // port C bits 7:6 are masked the same way on the small variant
    pec_edge_detect edgeC (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (port_c_pin),
        .rise   (riseC),
        .fall   (fallC)
    );

    // ==========================================================
    // helper functions shared by all three ports
    // kept as functions so the three ports cannot drift apart

    // enabled edge events of one port; a pin with both enables clear
    // can never produce one
    // the port mask keeps unimplemented pins out of every event
    function [7:0] pinEvents;
        input [7:0] rEn;
        input [7:0] fEn;
        input [7:0] r;
        input [7:0] f;
        input [7:0] m;
        begin
            pinEvents = ((rEn & r) | (fEn & f)) & m;
        end
    endfunction

    // next value of a flag byte: software value first, then hardware
    // events on top so a set in the clear cycle is never lost
    // trade-off: the written byte is taken whole, so clearing one
    // flag means writing back the others that should stay set
    function [7:0] flagNext;
        input [7:0] cur;
        input       wr;
        input [7:0] wd;
        input [7:0] evt;
        input [7:0] m;
        begin
            flagNext = (((wr ? wd : cur) | evt) & m);
        end
    endfunction

    // byte zero-extended into a bus word
    // so the upper bytes of every register read as zero
    function [31:0] toWord;
        input [7:0] b;
        begin
            toWord = {24'h000000, b};
        end
    endfunction

    // ==========================================================
    // edge events per port
    // an event is a single pulse; the flag byte is what holds it
    wire [7:0] evtA = pinEvents(port_a_rise_enable, port_a_fall_enable,
                                riseA, fallA, MASK_A);
    wire [7:0] evtB = pinEvents(port_b_rise_enable, port_b_fall_enable,
                                riseB, fallB, MASK_B);
    wire [7:0] evtC = pinEvents(port_c_rise_enable, port_c_fall_enable,
                                riseC, fallC, MASK_C);

    // ==========================================================
    // bus decode
    // a write takes effect at the edge where ack is seen high
    // only byte lane zero carries a register; the other lanes are
    // ignored, so a wide write never touches the upper bits
    wire       busReq  = wb_cyc_i & wb_stb_i;        // request present
    wire       wrLow   = busReq & wb_ack_o & wb_we_i & wb_sel_i[0];
    wire [7:0] wd      = wb_dat_i[7:0];              // written byte
    // port A registers
    wire       wrAR    = wrLow & (wb_adr_i == `PEC_OFS_A_RISE);
    wire       wrAF    = wrLow & (wb_adr_i == `PEC_OFS_A_FALL);
    wire       wrAG    = wrLow & (wb_adr_i == `PEC_OFS_A_FLAGS);
    // port B registers
    wire       wrBR    = wrLow & (wb_adr_i == `PEC_OFS_B_RISE);
    wire       wrBF    = wrLow & (wb_adr_i == `PEC_OFS_B_FALL);
    wire       wrBG    = wrLow & (wb_adr_i == `PEC_OFS_B_FLAGS);
    // port C registers
    wire       wrCR    = wrLow & (wb_adr_i == `PEC_OFS_C_RISE);
    wire       wrCF    = wrLow & (wb_adr_i == `PEC_OFS_C_FALL);
    wire       wrCG    = wrLow & (wb_adr_i == `PEC_OFS_C_FLAGS);
    // control, status and mask
    wire       wrIC    = wrLow & (wb_adr_i == `PEC_OFS_INTCTL);
    wire       wrST    = wrLow & (wb_adr_i == `PEC_OFS_STATUS);
    wire       wrMK    = wrLow & (wb_adr_i == `PEC_OFS_MASK);

    // ==========================================================
    // next flag values, shared by storage and interrupt logic
    // computed once here so the stored flags and the registered
    // interrupt agree in the same cycle
    reg [7:0] next_flagsA;   // port A flags after this edge
    reg [7:0] next_flagsB;   // port B flags after this edge
    reg [7:0] next_flagsC;   // port C flags after this edge
    reg [`PEC_ST_W-1:0] next_status; // event status after this edge
    reg       next_common;   // common flag after this edge
    reg       next_irq;      // interrupt level after this edge

    always @* begin
        // writing zero clears a flag, writing one sets it, an edge sets it
        next_flagsA = flagNext(port_a_change_flags, wrAG, wd, evtA,
                               MASK_A);
        next_flagsB = flagNext(port_b_change_flags, wrBG, wd, evtB,
                               MASK_B);
        next_flagsC = flagNext(port_c_change_flags, wrCG, wd, evtC,
                               MASK_C);
        // common flag follows the pin flags, so it drops only when
        // every pin flag has been cleared
        next_common = |{next_flagsA, next_flagsB, next_flagsC};
        // sticky per-port status, write one to clear, set wins
        // (a port event in the clearing write's cycle keeps its bit)
        next_status = eventStatus & ~(wrST ? wd[`PEC_ST_W-1:0]
                                           : `PEC_RST_ST);
        next_status[`PEC_ST_A] = next_status[`PEC_ST_A] | (|evtA);
        next_status[`PEC_ST_B] = next_status[`PEC_ST_B] | (|evtB);
        next_status[`PEC_ST_C] = next_status[`PEC_ST_C] | (|evtC);
        // either path may raise the single interrupt line
        // the enable comes from the write in flight, so a flag that
        // is already set raises irq on the very write that enables it
        next_irq = (next_common & (wrIC ? wd[`PEC_BIT_CEN]
                                        : common_change_interrupt_enable))
                 | (|(next_status & (wrMK ? wd[`PEC_ST_W-1:0]
                                          : eventMask)));
    end

    // ==========================================================
    // register storage; everything clears at reset
    // irq is registered from next values: it moves in the same cycle
    // as the flag it reflects, with no extra cycle of lag
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port_a_rise_enable  <= `PEC_RST_BYTE;
            port_a_fall_enable  <= `PEC_RST_BYTE;
            port_a_change_flags <= `PEC_RST_BYTE;
            port_b_rise_enable  <= `PEC_RST_BYTE;
            port_b_fall_enable  <= `PEC_RST_BYTE;
            port_b_change_flags <= `PEC_RST_BYTE;
            port_c_rise_enable  <= `PEC_RST_BYTE;
            port_c_fall_enable  <= `PEC_RST_BYTE;
            port_c_change_flags <= `PEC_RST_BYTE;
            common_change_interrupt_enable <= 1'b0;
            eventStatus <= `PEC_RST_ST;
            eventMask   <= `PEC_RST_ST;
            irq         <= 1'b0;
        end else begin
            // enables: unimplemented bits are dropped on write
            if (wrAR) begin
                port_a_rise_enable <= wd & MASK_A;
            end
            if (wrAF) begin
                port_a_fall_enable <= wd & MASK_A;
            end
            if (wrBR) begin
                port_b_rise_enable <= wd & MASK_B;
            end
            if (wrBF) begin
                port_b_fall_enable <= wd & MASK_B;
            end
            if (wrCR) begin
                port_c_rise_enable <= wd & MASK_C;
            end
            if (wrCF) begin
                port_c_fall_enable <= wd & MASK_C;
            end
            if (wrIC) begin
                common_change_interrupt_enable <= wd[`PEC_BIT_CEN];
            end
            if (wrMK) begin
                eventMask <= wd[`PEC_ST_W-1:0];
            end
            // flags and status update every cycle
            // (hardware sets and software writes meet in next_* above)
            port_a_change_flags <= next_flagsA;
            port_b_change_flags <= next_flagsB;
            port_c_change_flags <= next_flagsC;
            eventStatus         <= next_status;
            irq                 <= next_irq;
        end
    end

    // ==========================================================
    // common flag as stored state, read through interrupt control
    // it needs no write path: it falls when the last pin flag does,
    // and as a flop it keeps the wide OR off the read path
    reg common_change_interrupt_flag; // OR of all pin flags

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            common_change_interrupt_flag <= 1'b0;
        end else begin
            common_change_interrupt_flag <= next_common;
        end
    end

    // ==========================================================
    // read multiplexer; unmapped offsets read as zero
    // combinational here; the slave registers its output, so a long
    // decode never sits directly on the bus pins
    reg [31:0] rdWord; // word for the current address

    always @* begin
        case (wb_adr_i)
            `PEC_OFS_A_RISE:  rdWord = toWord(port_a_rise_enable);
            `PEC_OFS_A_FALL:  rdWord = toWord(port_a_fall_enable);
            `PEC_OFS_A_FLAGS: rdWord = toWord(port_a_change_flags);
            `PEC_OFS_B_RISE:  rdWord = toWord(port_b_rise_enable);
            `PEC_OFS_B_FALL:  rdWord = toWord(port_b_fall_enable);
            `PEC_OFS_B_FLAGS: rdWord = toWord(port_b_change_flags);
            `PEC_OFS_C_RISE:  rdWord = toWord(port_c_rise_enable);
            `PEC_OFS_C_FALL:  rdWord = toWord(port_c_fall_enable);
            `PEC_OFS_C_FLAGS: rdWord = toWord(port_c_change_flags);
            // interrupt control: enable in bit 3, common flag in bit 0
            `PEC_OFS_INTCTL: begin
                rdWord = `PEC_RST_WORD;
                rdWord[`PEC_BIT_CEN]   = common_change_interrupt_enable;
                rdWord[`PEC_BIT_CFLAG] = common_change_interrupt_flag;
            end
            // event status and mask share one layout, a bit per port
            `PEC_OFS_STATUS: begin
                rdWord = `PEC_RST_WORD;
                rdWord[`PEC_ST_W-1:0] = eventStatus;
            end
            `PEC_OFS_MASK: begin
                rdWord = `PEC_RST_WORD;
                rdWord[`PEC_ST_W-1:0] = eventMask;
            end
            default: rdWord = `PEC_RST_WORD;
        endcase
    end

    // ==========================================================
    // wishbone handshake: ack one cycle after the request, dropped
    // the next cycle; read data is captured with the ack so it stands
    // still while the master samples it
    // limitation: a request held on past ack is taken again, so the
    // master must drop cyc and stb after every ack
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `PEC_RST_WORD;
        end else begin
            wb_ack_o <= busReq & ~wb_ack_o;
            if (busReq & ~wb_ack_o) begin
                // every offset answers; a write reads back zero data
                wb_dat_o <= wb_we_i ? `PEC_RST_WORD : rdWord;
            end
        end
    end

endmodule

// File: pec_top_chk.sv
// concurrent checks on the ports of the pin edge change block
`include "pec_defs.vh"

module pec_top_chk #(
    parameter LARGE_VARIANT = 1          // mirrors the design parameter
) (
    input wire        clk,               // system clock
    input wire        arst_n,            // async reset, active low
    input wire [7:0]  port_a_pin,        // port A pins
    input wire [7:0]  port_b_pin,        // port B pins
    input wire [7:0]  port_c_pin,        // port C pins
    input wire        wb_cyc_i,          // bus cycle
    input wire        wb_stb_i,          // bus strobe
    input wire        wb_we_i,           // bus write enable
    input wire [7:0]  wb_adr_i,          // bus byte address
    input wire [31:0] wb_dat_o,          // bus read data
    input wire        wb_ack_o,          // bus acknowledge
    input wire        irq                // level interrupt
);
    timeunit 1ns;
    timeprecision 1ns;

    reg [23:0] pinPrev;                  // last pin sample
    reg [5:0]  chgHist;                  // recent pin changes, newest in bit 0
    reg        wrAck;                    // a write was acked last edge
    wire       rdAck = wb_ack_o && !wb_we_i; // read answer present

    // ==========================================================
    // helper history: irq may only move after a pin change or a write
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pinPrev <= 24'h000000;
            chgHist <= 6'h00;
            wrAck   <= 1'b0;
        end else begin
            pinPrev <= {port_a_pin, port_b_pin, port_c_pin};
            chgHist <= {chgHist[4:0], pinPrev != {port_a_pin, port_b_pin, port_c_pin}};
            wrAck   <= wb_ack_o && wb_we_i;
        end
    end

    // ==========================================================
    // assertions, one clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_read_width: assert property (rdAck |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_unmapped_zero: assert property (rdAck && wb_adr_i > `PEC_OFS_MASK |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_b_low_zero: assert property (rdAck && wb_adr_i >= `PEC_OFS_B_RISE
        && wb_adr_i <= `PEC_OFS_B_FLAGS |-> wb_dat_o[3:0] == 4'h0
        && (LARGE_VARIANT != 0 || wb_dat_o[7:0] == 8'h00))
        else $error("port B unimplemented bits not zero");
    a_a_top_zero: assert property (rdAck && wb_adr_i <= `PEC_OFS_A_FLAGS
        |-> wb_dat_o[7:6] == 2'h0)
        else $error("port A bits 7:6 not zero");
    a_irq_cause: assert property ($rose(irq) |-> wrAck || (|chgHist))
        else $error("irq rose without pin change or write");
    a_irq_fall: assert property ($fell(irq) |-> wrAck)
        else $error("irq fell without a software write");
endmodule

bind pec_top pec_top_chk #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (
    .clk(clk), .arst_n(arst_n), .port_a_pin(port_a_pin), .port_b_pin(port_b_pin),
    .port_c_pin(port_c_pin), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));

// File: pec_pin_model.sv
// model of the external pins driving the three ports
module pec_pin_model (
    input  wire       clk,               // system clock
    input  wire [7:0] wantA,             // requested port A level
    input  wire [7:0] wantB,             // requested port B level
    input  wire [7:0] wantC,             // requested port C level
    output reg  [7:0] pinA = 8'h00,      // port A pins
    output reg  [7:0] pinB = 8'h00,      // port B pins
    output reg  [7:0] pinC = 8'h00       // port C pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // levels move just after an edge and stand many cycles, never glitching
    always @(posedge clk) begin
        pinA <= wantA;
        pinB <= wantB;
        pinC <= wantC;
    end
endmodule

// File: tb_top.sv
// self-checking testbench for the pin edge change block
`include "pec_defs.vh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, arst_n, cyc, stb, we, ack, irq; // clock, reset, bus, irq
    logic [7:0]  adr, wantA, wantB, wantC;           // address, pin requests
    logic [7:0]  pinA, pinB, pinC;                   // pins from the model
    logic [3:0]  sel;                                // byte lanes
    logic [31:0] datW, datR;                         // bus data
    int          num_errors, n_checks;               // counters
    logic        ackS, irqS;                         // small variant answers
    logic [31:0] datS;                               // small variant read data
    logic [7:0]  lastS;                              // small variant byte of last read

    pec_top #(.LARGE_VARIANT(1)) uut (.clk(clk), .arst_n(arst_n), .port_a_pin(pinA),
        .port_b_pin(pinB), .port_c_pin(pinC), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
        .wb_dat_o(datR), .wb_ack_o(ack), .irq(irq));
    pec_pin_model u_pins (.clk(clk), .wantA(wantA), .wantB(wantB), .wantC(wantC),
        .pinA(pinA), .pinB(pinB), .pinC(pinC));
    // small variant on the same bus and pins; its ack comes with the large one's
    pec_top #(.LARGE_VARIANT(0)) uutSmall (.clk(clk), .arst_n(arst_n), .port_a_pin(pinA),
        .port_b_pin(pinB), .port_c_pin(pinC), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
        .wb_dat_o(datS), .wb_ack_o(ackS), .irq(irqS));

    // ==========================================================
    // clock and helpers
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task chk(input [31:0] got, input [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task print_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one classic cycle; a missing ack counts as a mismatch
    task xfer(input [7:0] a, input w, input [7:0] d, output [7:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= a;
        datW <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) num_errors++;
        q = datR[7:0];
        lastS = datS[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task wr(input [7:0] a, input [7:0] d);
        logic [7:0] q;
        xfer(a, 1'b1, d, q);
    endtask

    task rdChk(input [7:0] a, input [7:0] e);
        logic [7:0] q;
        xfer(a, 1'b0, 8'h00, q);
        chk({24'h0, q}, {24'h0, e});
    endtask

    // all pins to one level, then the detect latency passes
    task pinsTo(input [7:0] v);
        wantA <= v;
        wantB <= v;
        wantC <= v;
        repeat (6) @(posedge clk);
    endtask

    // ==========================================================
    // scenarios
    task tReset;
        for (int o = 0; o <= 'h30; o += 4) rdChk(8'(o), 8'h00);
    endtask

    task tMasks;
        logic [7:0] m, mS;
        for (int i = 0; i < 9; i++) begin
            m = i < 3 ? `PEC_MASK_A : (i < 6 ? `PEC_MASK_B_BIG : `PEC_MASK_C_BIG);
            mS = i < 3 ? `PEC_MASK_A : (i < 6 ? `PEC_MASK_B_SMALL : `PEC_MASK_C_SMALL);
            wr(8'(i * 4), 8'hff);
            rdChk(8'(i * 4), m);
            chk({24'h0, lastS}, {24'h0, mS});
            wr(8'(i * 4), 8'h00);
        end
    endtask

    task tPort(input int p);
        logic [7:0] m, b, mS;
        b = 8'(p * 12);
        m = p == 0 ? `PEC_MASK_A : (p == 1 ? `PEC_MASK_B_BIG : `PEC_MASK_C_BIG);
        mS = p == 0 ? `PEC_MASK_A : (p == 1 ? `PEC_MASK_B_SMALL : `PEC_MASK_C_SMALL);
        wr(b, m);
        pinsTo(8'hff);
        rdChk(b + 8'h08, m);
        chk({24'h0, lastS}, {24'h0, mS});
        rdChk(`PEC_OFS_INTCTL, 8'h01);
        chk({31'h0, irq}, 32'h0);
        wr(b + 8'h08, 8'h00);
        rdChk(b + 8'h08, 8'h00);
        rdChk(`PEC_OFS_INTCTL, 8'h00);
        pinsTo(8'h00);
        rdChk(b + 8'h08, 8'h00);
        wr(b, 8'h00);
        wr(b + 8'h04, m);
        pinsTo(8'hff);
        rdChk(b + 8'h08, 8'h00);
        pinsTo(8'h00);
        rdChk(b + 8'h08, m);
        wr(b + 8'h08, 8'h00);
        wr(b + 8'h04, 8'h00);
        pinsTo(8'hff);
        pinsTo(8'h00);
        rdChk(b + 8'h08, 8'h00);
    endtask

    task tIrq;
        wr(`PEC_OFS_STATUS, 8'h07);
        rdChk(`PEC_OFS_STATUS, 8'h00);
        wr(`PEC_OFS_INTCTL, 8'h08);
        wr(`PEC_OFS_A_RISE, 8'h01);
        pinsTo(8'h01);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, irqS}, 32'h1);
        wr(`PEC_OFS_A_FLAGS, 8'h00);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(`PEC_OFS_INTCTL, 8'h00);
        wr(`PEC_OFS_MASK, 8'h01);
        pinsTo(8'h00);
        pinsTo(8'h01);
        rdChk(`PEC_OFS_STATUS, 8'h01);
        wr(`PEC_OFS_A_FLAGS, 8'h00);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(`PEC_OFS_STATUS, 8'h01);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask

    // ==========================================================
    // main sequence, with a second reset in mid-run
    initial begin
        arst_n = 1'b0;
        {cyc, stb, we} = 3'h0;
        {adr, wantA, wantB, wantC} = 32'h0;
        sel = 4'h0;
        datW = 32'h0;
        num_errors = 0;
        n_checks = 0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        tReset;
        tMasks;
        for (int p = 0; p < 3; p++) tPort(p);
        tIrq;
        wr(`PEC_OFS_C_FALL, 8'h55);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        tReset;
        print_verdict;
    end

    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict;
    end
endmodule
